// *** pkg/pbc_defs.svh ***
/*
  offsets, width, reset values and codes of the port bit configuration block.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH
`define PBC_WIDTH 8
`define PBC_OFS_DATA 2'h0
`define PBC_OFS_CFG_LOW 2'h1
`define PBC_OFS_CFG_MID 2'h2
`define PBC_OFS_CFG_HIGH 2'h3
`define PBC_RST_DATA 8'hff
`define PBC_RST_CFG 8'h00
`define PBC_CODE_BID_WP 3'h0
`define PBC_CODE_BID_OD 3'h4
`define PBC_CODE_OUT_PP 3'h2
`define PBC_CODE_OUT_OD 3'h6
`define PBC_CODE_IN_CMOS 3'h1
`define PBC_CODE_IN_TTL 3'h5
`define PBC_CODE_AF_PP 3'h3
`define PBC_CODE_AF_OD 3'h7
`endif

// *** pkg/pbc_pkg.sv ***
/*
  types of the port bit configuration block.
  assumes pbc_defs.svh on the include path.
*/
`include "pbc_defs.svh"
package pbc_pkg;
  typedef enum logic [2:0] {
    PBC_MODE_BID,
    PBC_MODE_OUT,
    PBC_MODE_IN,
    PBC_MODE_PERIPHERAL_OUTPUT_MODE,
    PBC_MODE_PERIPHERAL_INPUT_MODE
  } pbc_mode_t;

  // decoded per-pin attributes
  typedef struct packed {
    pbc_mode_t mode;
    logic drv_en;
    logic open_drain;
    logic weak_pu;
    logic cmos_in;
    logic schmitt;
    logic analog;
  } pbc_pin_cfg_t;

  // register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } pbc_reg_req_t;
endpackage : pbc_pkg

// *** design/pbc_pin_decode.sv ***
/*
  decodes the three control bits of one pin into drive and input attributes.
  assumes hardware straps are constants per pin.
*/
`timescale 1ns/1ps
`include "pbc_defs.svh"
module pbc_pin_decode
  import pbc_pkg::*;
#(
  parameter bit HAS_PULLUP = 1'b1,
  parameter bit HAS_SCHMITT = 1'b0,
  parameter bit IS_ANALOG = 1'b0
) (
  input wire logic [2:0] i_code,
  output pbc_pin_cfg_t o_cfg
);
  always_comb begin
    o_cfg = '0;
    o_cfg.schmitt = HAS_SCHMITT;
    o_cfg.cmos_in = (i_code == `PBC_CODE_IN_CMOS) && !HAS_SCHMITT;
    case (i_code)
      `PBC_CODE_BID_WP: begin
        o_cfg.mode = PBC_MODE_BID;
        o_cfg.drv_en = 1'b1;
        o_cfg.open_drain = 1'b1;
        o_cfg.weak_pu = HAS_PULLUP;
      end
      `PBC_CODE_BID_OD: begin
        o_cfg.mode = PBC_MODE_BID;
        o_cfg.drv_en = 1'b1;
        o_cfg.open_drain = 1'b1;
      end
      `PBC_CODE_OUT_PP: begin
        o_cfg.mode = PBC_MODE_OUT;
        o_cfg.drv_en = 1'b1;
      end
      `PBC_CODE_OUT_OD: begin
        o_cfg.mode = PBC_MODE_OUT;
        o_cfg.drv_en = 1'b1;
        o_cfg.open_drain = 1'b1;
      end
      `PBC_CODE_AF_PP: begin
        o_cfg.mode = PBC_MODE_PERIPHERAL_OUTPUT_MODE;
        o_cfg.drv_en = 1'b1;
      end
      `PBC_CODE_AF_OD: begin
        if (IS_ANALOG) begin
          o_cfg.mode = PBC_MODE_PERIPHERAL_INPUT_MODE;
          o_cfg.analog = 1'b1;
        end else begin
          o_cfg.mode = PBC_MODE_PERIPHERAL_OUTPUT_MODE;
          o_cfg.drv_en = 1'b1;
          o_cfg.open_drain = 1'b1;
        end
      end
      default: begin
        o_cfg.mode = PBC_MODE_IN;
      end
    endcase
  end
endmodule : pbc_pin_decode

// *** design/pbc_port.sv ***
/*
  one 8-bit general purpose port: data and three control registers, latches,
  pad drive and peripheral routing.
  assumes the core gives one-cycle instruction start and end strobes and a
  register-file access port on the same clock; pads resolve the wire outside.
*/
`timescale 1ns/1ps
`include "pbc_defs.svh"
module pbc_port
  import pbc_pkg::*;
#(
  parameter int WIDTH = `PBC_WIDTH,
  parameter logic [WIDTH-1:0] PULLUP_MASK = '1,
  parameter logic [WIDTH-1:0] SCHMITT_MASK = '0,
  parameter logic [WIDTH-1:0] ANALOG_MASK = '0,
  parameter logic [WIDTH-1:0] AF_CONN_MASK = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pbc_reg_req_t i_req,
  output logic [7:0] o_rdata,
  input wire logic i_instr_start,
  input wire logic i_instr_end,
  input wire logic [WIDTH-1:0] i_pad,
  output logic [WIDTH-1:0] o_pad_out,
  output logic [WIDTH-1:0] o_pad_oe,
  output logic [WIDTH-1:0] o_pad_pullup,
  output logic [WIDTH-1:0] o_pad_cmos,
  output logic [WIDTH-1:0] o_pad_analog,
  input wire logic [WIDTH-1:0] i_peripheral_output_mode,
  output logic [WIDTH-1:0] o_peripheral_input_mode
);
  logic [WIDTH-1:0] cfg_high_r, cfg_high_nxt;
  logic [WIDTH-1:0] cfg_mid_r, cfg_mid_nxt;
  logic [WIDTH-1:0] cfg_low_r, cfg_low_nxt;
  logic [WIDTH-1:0] master_r, master_nxt;
  logic [WIDTH-1:0] slave_r, slave_nxt;
  logic [WIDTH-1:0] in_latch_r, in_latch_nxt;
  logic [WIDTH-1:0] pad_s1_r, pad_s2_r, pad_s3_r, pad_q_r, pad_q_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  pbc_pin_cfg_t pin_cfg [WIDTH];

  // three-stage pin synchroniser; level taken once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pad_s1_r <= '0;
      pad_s2_r <= '0;
      pad_s3_r <= '0;
      pad_q_r <= '0;
    end else begin
      pad_s1_r <= i_pad;
      pad_s2_r <= pad_s1_r;
      pad_s3_r <= pad_s2_r;
      pad_q_r <= pad_q_nxt;
    end
  end
  always_comb begin
    pad_q_nxt = pad_q_r;
    for (int k = 0; k < WIDTH; k++) begin
      if (pad_s2_r[k] == pad_s3_r[k]) begin
        pad_q_nxt[k] = pad_s3_r[k];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      pbc_pin_decode #(
        .HAS_PULLUP(PULLUP_MASK[g]),
        .HAS_SCHMITT(SCHMITT_MASK[g]),
        .IS_ANALOG(ANALOG_MASK[g])
      ) u_dec (
        .i_code({cfg_high_r[g], cfg_mid_r[g], cfg_low_r[g]}),
        .o_cfg(pin_cfg[g])
      );

      always_comb begin
        o_pad_oe[g] = 1'b0;
        o_pad_out[g] = 1'b0;
        o_pad_pullup[g] = pin_cfg[g].weak_pu;
        o_pad_cmos[g] = pin_cfg[g].cmos_in;
        o_pad_analog[g] = pin_cfg[g].analog;
        if (pin_cfg[g].drv_en) begin
          // open-drain only pulls low; a high level floats or rides the pull-up
          if (pin_cfg[g].open_drain) begin
            o_pad_oe[g] = ~slave_r[g];
            o_pad_out[g] = 1'b0;
          end else begin
            o_pad_oe[g] = 1'b1;
            o_pad_out[g] = slave_r[g];
          end
        end
        // pin level goes to every peripheral input regardless of mode
        o_peripheral_input_mode[g] = pad_q_r[g];
      end
    end
  endgenerate

  always_comb begin
    cfg_high_nxt = cfg_high_r;
    cfg_mid_nxt = cfg_mid_r;
    cfg_low_nxt = cfg_low_r;
    master_nxt = master_r;
    slave_nxt = slave_r;
    in_latch_nxt = in_latch_r;
    rdata_nxt = rdata_r;
    if (i_req.wr) begin
      case (i_req.addr)
        `PBC_OFS_DATA: master_nxt = i_req.wdata[WIDTH-1:0];
        `PBC_OFS_CFG_LOW: cfg_low_nxt = i_req.wdata[WIDTH-1:0];
        `PBC_OFS_CFG_MID: cfg_mid_nxt = i_req.wdata[WIDTH-1:0];
        `PBC_OFS_CFG_HIGH: cfg_high_nxt = i_req.wdata[WIDTH-1:0];
        default: master_nxt = master_r;
      endcase
    end
    if (i_req.rd) begin
      case (i_req.addr)
        `PBC_OFS_DATA: rdata_nxt = 8'(in_latch_r);
        `PBC_OFS_CFG_LOW: rdata_nxt = 8'(cfg_low_r);
        `PBC_OFS_CFG_MID: rdata_nxt = 8'(cfg_mid_r);
        `PBC_OFS_CFG_HIGH: rdata_nxt = 8'(cfg_high_r);
        default: rdata_nxt = 8'h00;
      endcase
    end
    for (int k = 0; k < WIDTH; k++) begin
      case (pin_cfg[k].mode)
        PBC_MODE_OUT: begin
          if (i_instr_end) begin
            slave_nxt[k] = master_r[k];
            in_latch_nxt[k] = master_r[k];
          end
        end
        PBC_MODE_PERIPHERAL_OUTPUT_MODE: begin
          if (i_instr_start) begin
            in_latch_nxt[k] = pad_q_r[k];
          end
          // missing peripheral output reads as one: push-pull high, open-drain floats
          slave_nxt[k] = AF_CONN_MASK[k] ? i_peripheral_output_mode[k] : 1'b1;
        end
        PBC_MODE_PERIPHERAL_INPUT_MODE: begin
          if (i_instr_start) begin
            in_latch_nxt[k] = pad_q_r[k];
          end
          slave_nxt[k] = 1'b1;
        end
        default: begin
          // bidirectional and input: sample at start, transfer at end
          if (i_instr_start) begin
            in_latch_nxt[k] = pad_q_r[k];
          end
          if (i_instr_end) begin
            slave_nxt[k] = master_r[k];
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_high_r <= WIDTH'(`PBC_RST_CFG);
      cfg_mid_r <= WIDTH'(`PBC_RST_CFG);
      cfg_low_r <= WIDTH'(`PBC_RST_CFG);
      master_r <= WIDTH'(`PBC_RST_DATA);
      slave_r <= WIDTH'(`PBC_RST_DATA);
      in_latch_r <= WIDTH'(`PBC_RST_DATA);
      rdata_r <= '0;
    end else begin
      cfg_high_r <= cfg_high_nxt;
      cfg_mid_r <= cfg_mid_nxt;
      cfg_low_r <= cfg_low_nxt;
      master_r <= master_nxt;
      slave_r <= slave_nxt;
      in_latch_r <= in_latch_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

  AST_OUT_END_COPY: assert property (@(posedge i_clk) disable iff (i_rst)
    (pin_cfg[0].mode == PBC_MODE_OUT && i_instr_end) |=> (slave_r[0] == $past(master_r[0]) &&
      in_latch_r[0] == $past(master_r[0])))
    else $error("output mode end copy wrong");
  AST_BID_START_SAMPLE: assert property (@(posedge i_clk) disable iff (i_rst)
    (pin_cfg[0].mode == PBC_MODE_BID && i_instr_start) |=> in_latch_r[0] == $past(pad_q_r[0]))
    else $error("bidirectional sample wrong");
  AST_IN_TRISTATE: assert property (@(posedge i_clk) disable iff (i_rst)
    (pin_cfg[1].mode == PBC_MODE_IN) |-> !o_pad_oe[1])
    else $error("input mode drives pin");
  AST_PP_DRIVE: assert property (@(posedge i_clk) disable iff (i_rst)
    ({cfg_high_r[2], cfg_mid_r[2], cfg_low_r[2]} == `PBC_CODE_OUT_PP) |-> (o_pad_oe[2] && o_pad_out[2] == slave_r[2]))
    else $error("push-pull not driving");
  AST_OD_NO_HIGH: assert property (@(posedge i_clk) disable iff (i_rst)
    pin_cfg[3].open_drain |-> !(o_pad_oe[3] && o_pad_out[3]))
    else $error("open-drain drove high");
  AST_CMOS_SEL: assert property (@(posedge i_clk) disable iff (i_rst)
    o_pad_cmos[4] |-> ({cfg_high_r[4], cfg_mid_r[4], cfg_low_r[4]} == `PBC_CODE_IN_CMOS))
    else $error("cmos on wrong code");
  AST_AF_FOLLOW: assert property (@(posedge i_clk) disable iff (i_rst)
    (pin_cfg[5].mode == PBC_MODE_PERIPHERAL_OUTPUT_MODE && $stable(pin_cfg[5].mode)) |=>
      slave_r[5] == (AF_CONN_MASK[5] ? $past(i_peripheral_output_mode[5]) : 1'b1))
    else $error("peripheral output not followed");
  AST_READ_INLATCH: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `PBC_OFS_DATA) |=> o_rdata == 8'($past(in_latch_r)))
    else $error("port read wrong");
  AST_WRITE_MASTER: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_req.wr && i_req.addr == `PBC_OFS_DATA) |=> master_r == $past(i_req.wdata[WIDTH-1:0]))
    else $error("port write lost");
  AST_PERIPHERAL_INPUT_MODE_ROUTE: assert property (@(posedge i_clk) disable iff (i_rst)
    (pad_s2_r == pad_s3_r) |=> o_peripheral_input_mode == $past(pad_s3_r))
    else $error("peripheral input not routed");
  AST_RESET_STATE: assert property (@(posedge i_clk)
    ($past(i_rst) && !i_rst) |-> (master_r == '1 && cfg_low_r == '0 && cfg_mid_r == '0 && cfg_high_r == '0))
    else $error("reset state wrong");
  // analog pass-through must never meet an enabled driver
  AST_ANALOG_OFF: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_pad_analog & o_pad_oe) == '0)
    else $error("analog pin driven");

  COV_OUT: cover property (@(posedge i_clk) pin_cfg[0].mode == PBC_MODE_OUT && i_instr_end);
  COV_BID: cover property (@(posedge i_clk) pin_cfg[0].mode == PBC_MODE_BID && i_instr_start);
  COV_AF: cover property (@(posedge i_clk) pin_cfg[5].mode == PBC_MODE_PERIPHERAL_OUTPUT_MODE);
  COV_RD: cover property (@(posedge i_clk) i_req.rd && i_req.addr == `PBC_OFS_DATA);
endmodule : pbc_port

// *** dv/pbc_pad_model.sv ***
/*
  pads and external circuit of the port: resolves each wire from the drive,
  a forced external level and the weak pull-up.
  assumes one clock; a floating pin shows the inverse of its last level.
*/
`timescale 1ns/1ps
module pbc_pad_model (
  input wire logic i_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pullup,
  input wire logic [7:0] i_force,
  input wire logic [7:0] i_fval,
  output logic [7:0] o_pad
);
  logic [7:0] float_r;
  logic [7:0] held;
  // a released pin keeps the inverse of its last held level, it does not toggle
  assign held = i_oe | i_force | i_pullup;
  always_ff @(posedge i_clk) begin
    float_r <= (held & ~o_pad) | (~held & float_r);
  end
  assign o_pad = (i_oe & i_out) | (~i_oe & i_force & i_fval) | (~i_oe & ~i_force & i_pullup)
               | (~i_oe & ~i_force & ~i_pullup & float_r);
endmodule : pbc_pad_model

// *** dv/pbc_port_tb_top.sv ***
/*
  self-checking bench of the port: register writes and reads, strobes, pads.
  assumes the pad model beside it and the design's package.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module pbc_port_tb_top;
  import pbc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  pbc_reg_req_t req = '0;
  logic st = 1'b0;
  logic en = 1'b0;
  logic [7:0] af = 8'h00;
  logic [7:0] frc = 8'h00;
  logic [7:0] fv = 8'h00;
  logic [7:0] pad, rdata, pout, poe, ppu, pcmos, pana, afin;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  always #2 i_clk = ~i_clk;
  pbc_port #(.PULLUP_MASK(8'hfe), .SCHMITT_MASK(8'h40), .ANALOG_MASK(8'h80), .AF_CONN_MASK(8'h0f)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_rdata(rdata), .i_instr_start(st), .i_instr_end(en),
    .i_pad(pad), .o_pad_out(pout), .o_pad_oe(poe), .o_pad_pullup(ppu), .o_pad_cmos(pcmos),
    .o_pad_analog(pana), .i_peripheral_output_mode(af), .o_peripheral_input_mode(afin));
  pbc_pad_model pads (.i_clk(i_clk), .i_out(pout), .i_oe(poe), .i_pullup(ppu), .i_force(frc),
    .i_fval(fv), .o_pad(pad));
  task automatic close_out();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  always @(posedge i_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    req <= '0;
    #1;
    d = rdata;
  endtask : rd
  task automatic cfg(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l);
    wr(2'h3, h);
    wr(2'h2, m);
    wr(2'h1, l);
    repeat (2) @(posedge i_clk);
  endtask : cfg
  // one-cycle core strobes, then two more cycles, short of the three-stage pad synchroniser
  task automatic strobe(input bit is_end);
    @(posedge i_clk);
    if (is_end) en <= 1'b1; else st <= 1'b1;
    @(posedge i_clk);
    en <= 1'b0;
    st <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : strobe
  logic [7:0] v;
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    `CHK(poe, 8'h00)
    `CHK(ppu, 8'hfe)
    rd(2'h0, v); `CHK(v, 8'hff)
    rd(2'h1, v); `CHK(v, 8'h00)
    $display("test reset done");
    cfg(8'h00, 8'hff, 8'h00);
    wr(2'h0, 8'h5a);
    strobe(1'b1);
    `CHK(poe, 8'hff)
    `CHK(pout, 8'h5a)
    rd(2'h0, v); `CHK(v, 8'h5a)
    cfg(8'hff, 8'hff, 8'h00); #1;
    `CHK(poe, 8'ha5)
    $display("test output done");
    frc <= 8'hff;
    fv <= 8'h3c;
    cfg(8'h00, 8'h00, 8'hff); #1;
    `CHK(poe, 8'h00)
    `CHK(pcmos, 8'hbf)
    repeat (6) @(posedge i_clk);
    strobe(1'b0);
    `CHK(afin, 8'h3c)
    rd(2'h0, v); `CHK(v, 8'h3c)
    cfg(8'hff, 8'h00, 8'hff); #1;
    `CHK(pcmos, 8'h00)
    `CHK(poe, 8'h00)
    $display("test input done");
    frc <= 8'h0d;
    fv <= 8'h01;
    cfg(8'h00, 8'h00, 8'h00);
    wr(2'h0, 8'h0f);
    strobe(1'b1);
    `CHK(poe, 8'hf0)
    repeat (6) @(posedge i_clk);
    strobe(1'b0);
    rd(2'h0, v); `CHK(v, 8'h03)
    wr(2'h0, v | 8'h80);
    strobe(1'b1);
    `CHK(poe, 8'h7c)
    cfg(8'hff, 8'h00, 8'h00); #1;
    `CHK(ppu, 8'h00)
    `CHK(poe, 8'h7c)
    $display("test bidirectional done");
    frc <= 8'h00;
    af <= 8'h0a;
    cfg(8'h00, 8'hff, 8'hff); #1;
    `CHK(poe, 8'hff)
    `CHK(pout, 8'hfa)
    repeat (6) @(posedge i_clk);
    strobe(1'b0);
    rd(2'h0, v); `CHK(v, 8'hfa)
    cfg(8'hff, 8'hff, 8'hff); #1;
    `CHK(poe, 8'h05)
    `CHK(pana, 8'h80)
    $display("test alternate done");
    close_out();
  end
endmodule : pbc_port_tb_top
